// ==== dv/sswp_ctrl_model.sv ====
/* pin-side model of the memory controller that drives the write port.
   assumes a free-running pin clock pair of HALF bench cycles per half period. */
module sswp_ctrl_model #(
   parameter int HALF = 4
) (
   input  wire logic                         clk,
   output logic                              k_clk_pin = 1'b0,
   output logic                              k_clk_n_pin = 1'b1,
   output logic                              write_port_select_n = 1'b1,
   output logic [sswp_pkg::ADDR_W-1:0]       addr_pin = '0,
   output logic [sswp_pkg::DATA_W-1:0]       data_pin = '0,
   output logic [sswp_pkg::MASK_W-1:0]       lane_write_mask_n = '0,
   output logic                              idle = 1'b1
);
   timeunit 1ns;
   timeprecision 1ps;
   import sswp_pkg::*;
   localparam int TOP = 4 * MASK_W + 4 * DATA_W + ADDR_W;
   logic [TOP:0]        q[$];
   logic [TOP:0]        cur;
   logic [ADDR_W-1:0]   a;
   logic [DATA_W-1:0]   d;
   logic [MASK_W-1:0]   m;
   logic                sel;
   logic                kn;
   logic                used;
   int                  ph = 0;
   int                  nb = 4;

   // ghost: select stays high, address still shown, data and mask only when no beat of the last burst holds the pins
   task automatic push(input logic g, input logic [ADDR_W-1:0] pa,
                       input logic [4*DATA_W-1:0] pd, input logic [4*MASK_W-1:0] pm);
      q.push_back({g, pa, pd, pm});
   endtask

   always @(posedge clk) begin
      ph = (ph + 1) % (2 * HALF);
      if (ph == 0 || ph == HALF) begin
         k_clk_pin <= (ph == 0);
         k_clk_n_pin <= (ph != 0);
      end
      if (ph == HALF / 2 || ph == HALF + HALF / 2) begin
         kn = (ph > HALF);
         used = 1'b0;
         sel = 1'b1;
         a = ~addr_pin;
         d = ~data_pin;
         m = ~lane_write_mask_n;
         // four beats, mask with its data
         if (nb < 4 && nb[0] == kn) begin
            d = cur[4 * MASK_W + nb * DATA_W +: DATA_W];
            m = cur[nb * MASK_W +: MASK_W];
            nb++;
            used = 1'b1;
         end
         // select only ahead of a true-clock rise
         if (kn && nb == 4 && q.size() > 0) begin
            cur = q.pop_front();
            a = cur[4 * MASK_W + 4 * DATA_W +: ADDR_W];
            sel = cur[TOP];
            if (!sel) begin
               nb = 0;
            end else if (!used) begin
               d = cur[4 * MASK_W +: DATA_W];
               m = cur[MASK_W-1:0];
            end
         end
         write_port_select_n <= sel;
         addr_pin <= a;
         data_pin <= d;
         lane_write_mask_n <= m;
      end
      idle <= (q.size() == 0) && (nb == 4);
   end
endmodule

// ==== dv/testbench.sv ====
/* self-checking bench for the write-port front end with a controller model.
   assumes one 125 MHz clock and a drain side stalled at random. */
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
   $display("Error t=%0t got %h exp %h", $time, g, e); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import sswp_pkg::*;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [BEAT_W-1:0] beat;
      logic [DATA_W-1:0] data;
      logic [DATA_W-1:0] en;
   } sswp_exp_s;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic wr_ready = 1'b0;
   logic hold = 1'b0;
   logic track = 1'b1;
   sswp_cfg_e word_cfg = SSWP_CFG_X8;
   logic k, kn, sel_n, ctrl_idle, wr_valid, overflow_reg, busy_reg;
   logic [ADDR_W-1:0] addr, wr_addr;
   logic [DATA_W-1:0] data, wr_data, wr_bit_en;
   logic [MASK_W-1:0] mask_n;
   logic [BEAT_W-1:0] wr_beat;
   logic [15:0] seed = 16'h0039;
   logic [15:0] rdy_seed = 16'h0039;
   sswp_exp_s exp_q[$];
   sswp_exp_s e;
   int n_errors = 0;
   int check_count = 0;

   always #4 clk = ~clk;

   sswp_ctrl_model #(.HALF(4)) i_ctrl (.clk(clk), .k_clk_pin(k), .k_clk_n_pin(kn),
      .write_port_select_n(sel_n), .addr_pin(addr), .data_pin(data),
      .lane_write_mask_n(mask_n), .idle(ctrl_idle));
   sswp_write_port i_dut (.clk(clk), .nrst(nrst), .k_clk_pin(k), .k_clk_n_pin(kn),
      .write_port_select_n(sel_n), .addr_pin(addr), .data_pin(data),
      .lane_write_mask_n(mask_n), .word_cfg(word_cfg), .wr_ready(wr_ready),
      .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_beat(wr_beat), .wr_data(wr_data),
      .wr_bit_en(wr_bit_en), .overflow_reg(overflow_reg), .busy_reg(busy_reg));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [DATA_W-1:0] en_of(input sswp_cfg_e c, input logic [3:0] m);
      logic [DATA_W-1:0] r;
      r = '0;
      case (c)
         SSWP_CFG_X8: r[7:0] = {{4{~m[1]}}, {4{~m[0]}}};
         SSWP_CFG_X9: r[8:0] = {9{~m[0]}};
         SSWP_CFG_X18: r[17:0] = {{9{~m[1]}}, {9{~m[0]}}};
         default: r = {{9{~m[3]}}, {9{~m[2]}}, {9{~m[1]}}, {9{~m[0]}}};
      endcase
      return r;
   endfunction

   // mode 0 random masks, 1 none masked, 2 all masked
   task automatic send(input logic g, input logic [1:0] mode);
      logic [4*DATA_W-1:0] d;
      logic [4*MASK_W-1:0] m;
      logic [ADDR_W-1:0]   a;
      for (int i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         d[i*12 +: 12] = seed[11:0];
      end
      seed = lfsr(seed);
      a = {seed, seed[3:0]};
      seed = lfsr(seed);
      m = (mode == 2'h0) ? seed : (mode == 2'h1 || g) ? 16'h0000 : 16'hFFFF;
      i_ctrl.push(g, a, d, m);
      for (int i = 0; i < 4 && !g && track; i++) begin
         e.en = en_of(word_cfg, m[i*4 +: 4]);
         exp_q.push_back({a, 2'(i), d[i*DATA_W +: DATA_W] & e.en, e.en});
      end
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 3000 && !(ctrl_idle && exp_q.size() == 0); i++) @(posedge clk);
      repeat (12) @(posedge clk);
   endtask

   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      rdy_seed = lfsr(rdy_seed);
      wr_ready <= !hold && rdy_seed[0];
      if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
         `CHK(exp_q.size() != 0, 1'b1)
         if (exp_q.size() != 0) begin
            e = exp_q.pop_front();
            `CHK({wr_addr, wr_beat, wr_data, wr_bit_en}, e)
         end
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      complete_run();
   end

   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      `CHK({wr_valid, busy_reg, overflow_reg}, 3'h0)
      for (int c = 0; c < 4; c++) begin
         word_cfg <= sswp_cfg_e'(c);
         @(posedge clk);
         for (int n = 0; n < 9; n++) send(n % 4 == 3, 2'(n % 3));
         wait_idle();
         `CHK({exp_q.size() == 0, busy_reg, overflow_reg}, 3'h4)
      end
      hold <= 1'b1;
      track = 1'b0;
      for (int n = 0; n < 10; n++) send(1'b0, 2'h1);
      repeat (20) @(posedge clk);
      `CHK(busy_reg, 1'b1)
      wait_idle();
      `CHK(overflow_reg, 1'b1)
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      hold <= 1'b0;
      track = 1'b1;
      repeat (4) @(posedge clk);
      `CHK({wr_valid, busy_reg, overflow_reg}, 3'h0)
      send(1'b0, 2'h0);
      send(1'b1, 2'h0);
      send(1'b0, 2'h2);
      wait_idle();
      `CHK(exp_q.size(), 0)
      complete_run();
   end
endmodule

// ==== hdl/sswp_fifo.sv ====
/*
 * Synchronous FIFO with parameterised width and depth, valid/ready both sides.
 * Read data come out of a register; assumes depth is a power of two.
 */
module sswp_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int unsigned PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr_reg;
   logic [PW-1:0]    rd_ptr_reg;
   logic [PW:0]      count_reg;
   logic             push;
   logic             pop;

   assign in_ready = (count_reg != DEPTH[PW:0]);
   assign push     = in_valid && in_ready;
   // refill the output register when it is empty or being taken
   assign pop      = (count_reg != '0) && (!out_valid || out_ready);

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         out_valid <= 1'b0;
         out_data  <= '0;
      end else if (pop) begin
         out_valid <= 1'b1;
         out_data  <= mem[rd_ptr_reg];
      end else if (out_ready) begin
         out_valid <= 1'b0;
      end
   end
endmodule

// ==== hdl/sswp_write_port.sv ====
/*
 * Write-port front end: oversamples the input clock pair and write pins,
 * captures four-beat write bursts with lane masks and queues them for the array.
 * Assumes clk is much faster than the pin clocks and the pins are stable
 * around each pin clock edge as seen after synchronisation.
 */
module sswp_write_port (
   input  wire logic                           clk,
   input  wire logic                           nrst,
   input  wire logic                           k_clk_pin,
   input  wire logic                           k_clk_n_pin,
   input  wire logic                           write_port_select_n,
   input  wire logic [sswp_pkg::ADDR_W-1:0]    addr_pin,
   input  wire logic [sswp_pkg::DATA_W-1:0]    data_pin,
   input  wire logic [sswp_pkg::MASK_W-1:0]    lane_write_mask_n,
   input  wire sswp_pkg::sswp_cfg_e            word_cfg,
   input  wire logic                           wr_ready,
   output logic                                wr_valid,
   output logic      [sswp_pkg::ADDR_W-1:0]    wr_addr,
   output logic      [sswp_pkg::BEAT_W-1:0]    wr_beat,
   output logic      [sswp_pkg::DATA_W-1:0]    wr_data,
   output logic      [sswp_pkg::DATA_W-1:0]    wr_bit_en,
   output logic                                overflow_reg,
   output logic                                busy_reg
);
   import sswp_pkg::*;

   logic [SYNC_W-1:0]  sync1_reg;
   logic [SYNC_W-1:0]  sync2_reg;
   logic               k_prev_reg;
   logic               kn_prev_reg;
   logic               k_s;
   logic               kn_s;
   logic               sel_n_s;
   logic [ADDR_W-1:0]  addr_s;
   logic [MASK_W-1:0]  mask_n_s;
   logic [DATA_W-1:0]  data_s;
   logic               k_rise;
   logic               kn_rise;
   sswp_state_e        state_reg;
   sswp_state_e        state_next;
   logic [ADDR_W-1:0]  addr_reg;
   logic [DATA_W-1:0]  bit_en;
   logic               beat_edge;
   logic               push;
   logic               fifo_in_ready;
   logic [BEAT_W-1:0]  beat_idx;
   logic [ENTRY_W-1:0] fifo_out;

   // all pins share one two-stage synchroniser so clocks and data stay aligned
   always_ff @(posedge clk) begin
      // clocks and select rest high so release shows no false rise or select
      if (!nrst) begin
         sync1_reg <= {3'b111, {(SYNC_W-3){1'b0}}};
         sync2_reg <= {3'b111, {(SYNC_W-3){1'b0}}};
      end else begin
         sync1_reg <= {k_clk_pin, k_clk_n_pin, write_port_select_n, addr_pin,
                       lane_write_mask_n, data_pin};
         sync2_reg <= sync1_reg;
      end
   end

   assign {k_s, kn_s, sel_n_s, addr_s, mask_n_s, data_s} = sync2_reg;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         k_prev_reg  <= 1'b1;
         kn_prev_reg <= 1'b1;
      end else begin
         k_prev_reg  <= k_s;
         kn_prev_reg <= kn_s;
      end
   end

   assign k_rise  = k_s && !k_prev_reg;
   assign kn_rise = kn_s && !kn_prev_reg;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SSWP_IDLE:  if (k_rise && !sel_n_s) state_next = SSWP_BEAT0;
         SSWP_BEAT0: if (kn_rise) state_next = SSWP_BEAT1;
         SSWP_BEAT1: if (k_rise) state_next = SSWP_BEAT2;
         SSWP_BEAT2: if (kn_rise) state_next = SSWP_BEAT3;
         SSWP_BEAT3: begin
            if (k_rise) begin
               state_next = sel_n_s ? SSWP_IDLE : SSWP_BEAT0;
            end
         end
         default:    state_next = SSWP_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_reg <= SSWP_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // address held only when a write is selected
   always_ff @(posedge clk) begin
      if (!nrst) begin
         addr_reg <= '0;
      end else if (k_rise && !sel_n_s &&
                   (state_reg == SSWP_IDLE || state_reg == SSWP_BEAT3)) begin
         addr_reg <= addr_s;
      end
   end

   // beats only taken on edges inside a write
   always_comb begin
      case (state_reg)
         SSWP_BEAT0: begin beat_edge = kn_rise; beat_idx = BEAT_IDX0; end
         SSWP_BEAT1: begin beat_edge = k_rise;  beat_idx = BEAT_IDX1; end
         SSWP_BEAT2: begin beat_edge = kn_rise; beat_idx = BEAT_IDX2; end
         SSWP_BEAT3: begin beat_edge = k_rise;  beat_idx = BEAT_IDX3; end
         default:    begin beat_edge = 1'b0;    beat_idx = BEAT_IDX0; end
      endcase
   end

   assign push = beat_edge;

   // per-bit write enable from the masks of this beat
   for (genvar i = 0; i < DATA_W; i++) begin : g_bit_en
      localparam int NIB  = (i / NIBBLE_W) % 2;
      localparam int LANE = i / LANE_W;
      localparam int LANE18 = LANE % 2;
      always_comb begin
         case (word_cfg)
            SSWP_CFG_X8:  bit_en[i] = (i < X8_BITS) && !mask_n_s[NIB];
            SSWP_CFG_X9:  bit_en[i] = (i < X9_BITS) && !mask_n_s[0];
            SSWP_CFG_X18: bit_en[i] = (i < X18_BITS) && !mask_n_s[LANE18];
            default:      bit_en[i] = !mask_n_s[LANE];
         endcase
      end
   end

   // mask and data of one beat enqueued together
   sswp_fifo #(
      .WIDTH (ENTRY_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .nrst      (nrst),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   ({addr_reg, beat_idx, data_s & bit_en, bit_en}),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (fifo_out)
   );

   assign {wr_addr, wr_beat, wr_data, wr_bit_en} = fifo_out;

   // pins cannot be stalled, so a beat arriving while full is lost and flagged
   always_ff @(posedge clk) begin
      if (!nrst) begin
         overflow_reg <= 1'b0;
      end else if (push && !fifo_in_ready) begin
         overflow_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= (state_next != SSWP_IDLE);
      end
   end

   sequence seq_select;
      state_reg == SSWP_IDLE && k_rise && !sel_n_s;
   endsequence

   sequence seq_beat3_done;
      state_reg == SSWP_BEAT3 && k_rise;
   endsequence

   AST_SELECT_STARTS: assert property (
      @(posedge clk) disable iff (!nrst)
      seq_select |=> state_reg == SSWP_BEAT0 && addr_reg == $past(addr_s))
      else $error("selected write did not start");

   AST_DESELECT_IGNORED: assert property (
      @(posedge clk) disable iff (!nrst)
      state_reg == SSWP_IDLE && k_rise && sel_n_s |=> state_reg == SSWP_IDLE)
      else $error("deselected port left idle");

   AST_ADDR_STABLE: assert property (
      @(posedge clk) disable iff (!nrst)
      state_reg inside {SSWP_BEAT0, SSWP_BEAT1, SSWP_BEAT2} |=> $stable(addr_reg))
      else $error("address changed inside a burst");

   AST_NO_BEAT_IDLE: assert property (
      @(posedge clk) disable iff (!nrst)
      state_reg == SSWP_IDLE |-> !push)
      else $error("beat taken outside a write");

   AST_BEAT_EDGES: assert property (
      @(posedge clk) disable iff (!nrst)
      push |-> ((beat_idx[0] == 1'b0) ? kn_rise : k_rise))
      else $error("beat taken on wrong clock edge");

   AST_X8_NIBBLES: assert property (
      @(posedge clk) disable iff (!nrst)
      push && word_cfg == SSWP_CFG_X8 |->
      bit_en == {28'h0, {4{!mask_n_s[1]}}, {4{!mask_n_s[0]}}})
      else $error("nibble enables wrong");

   AST_X18_LANES: assert property (
      @(posedge clk) disable iff (!nrst)
      push && word_cfg == SSWP_CFG_X18 |->
      bit_en == {18'h0, {9{!mask_n_s[1]}}, {9{!mask_n_s[0]}}})
      else $error("x18 lane enables wrong");

   AST_X36_MASKED: assert property (
      @(posedge clk) disable iff (!nrst)
      push && word_cfg == SSWP_CFG_X36 && mask_n_s[3] |->
      bit_en[35:27] == 9'h000)
      else $error("masked lane enabled");

   AST_X36_LANES: assert property (
      @(posedge clk) disable iff (!nrst)
      push && word_cfg == SSWP_CFG_X36 |->
      bit_en == {{9{!mask_n_s[3]}}, {9{!mask_n_s[2]}}, {9{!mask_n_s[1]}}, {9{!mask_n_s[0]}}})
      else $error("x36 lane enables wrong");

   AST_X9_LANE: assert property (
      @(posedge clk) disable iff (!nrst)
      push && word_cfg == SSWP_CFG_X9 |->
      bit_en == {27'h0, {9{!mask_n_s[0]}}})
      else $error("x9 lane enables wrong");

   AST_BUSY_ON_SELECT: assert property (
      @(posedge clk) disable iff (!nrst)
      seq_select |=> busy_reg)
      else $error("busy not raised by a selected write");

   AST_ADDR_DESELECT: assert property (
      @(posedge clk) disable iff (!nrst)
      seq_beat3_done and (sel_n_s == 1'b1) |=> $stable(addr_reg))
      else $error("address taken while deselected");

   AST_BURST_ENDS: assert property (
      @(posedge clk) disable iff (!nrst)
      seq_beat3_done |=> state_reg inside {SSWP_IDLE, SSWP_BEAT0})
      else $error("burst did not end after four beats");
endmodule

// ==== shared/sswp_pkg.sv ====
/*
 * Shared constants and types for the synchronous SRAM write-port front end.
 * Assumes a single 125 MHz system clock that oversamples the pin clock pair.
 */
package sswp_pkg;
   localparam int unsigned ADDR_W   = 20;
   localparam int unsigned DATA_W   = 36;
   localparam int unsigned MASK_W   = 4;
   localparam int unsigned BEAT_W   = 2;
   localparam int unsigned SYNC_W   = 3 + ADDR_W + MASK_W + DATA_W;
   localparam int unsigned ENTRY_W  = ADDR_W + BEAT_W + DATA_W + DATA_W;
   localparam int unsigned FIFO_DEPTH = 32;
   localparam int unsigned NIBBLE_W = 4;
   localparam int unsigned LANE_W   = 9;
   localparam int unsigned X8_BITS  = 8;
   localparam int unsigned X9_BITS  = 9;
   localparam int unsigned X18_BITS = 18;
   localparam int unsigned CLK_MHZ  = 125;

   typedef enum logic [1:0] {
      SSWP_CFG_X8  = 2'h0,
      SSWP_CFG_X9  = 2'h1,
      SSWP_CFG_X18 = 2'h2,
      SSWP_CFG_X36 = 2'h3
   } sswp_cfg_e;

   typedef enum logic [2:0] {
      SSWP_IDLE  = 3'h0,
      SSWP_BEAT0 = 3'h1,
      SSWP_BEAT1 = 3'h3,
      SSWP_BEAT2 = 3'h2,
      SSWP_BEAT3 = 3'h6
   } sswp_state_e;

   localparam logic [BEAT_W-1:0] BEAT_IDX0 = 2'h0;
   localparam logic [BEAT_W-1:0] BEAT_IDX1 = 2'h1;
   localparam logic [BEAT_W-1:0] BEAT_IDX2 = 2'h2;
   localparam logic [BEAT_W-1:0] BEAT_IDX3 = 2'h3;
endpackage
